// ==== hdl/ldpd_pkg.sv ====
// Constants for the lock detect and pin drive block
package ldpd_pkg;
   // Register offsets
   localparam logic [7:0] LDPD_OFS_CP_HIGH_MONITOR = 8'h1f;
   localparam logic [7:0] LDPD_OFS_LOCK_PASS_FILTER = 8'h21;
   localparam logic [7:0] LDPD_OFS_LOCK_ERROR_AND_WINDOW = 8'h22;
   localparam logic [7:0] LDPD_OFS_TRIGGER1_PIN_CONFIG = 8'h24;
   localparam logic [7:0] LDPD_OFS_TRIGGER2_PIN_CONFIG = 8'h25;
   localparam logic [7:0] LDPD_OFS_MODULATION_PIN_CONFIG = 8'h26;
   localparam logic [7:0] LDPD_OFS_MUX_OUTPUT_PIN_CONFIG = 8'h27;
   localparam logic [7:0] LDPD_OFS_IRQ_STATUS = 8'h28;
   localparam logic [7:0] LDPD_OFS_IRQ_CLEAR = 8'h29;
   localparam logic [7:0] LDPD_OFS_IRQ_ENABLE = 8'h2a;
   // Field positions
   localparam int LDPD_HTHR_LSB = 0;
   localparam int LDPD_HTHR_MSB = 5;
   localparam int LDPD_HFLAG_BIT = 6;
   localparam int LDPD_ERRC_LSB = 0;
   localparam int LDPD_ERRC_MSB = 4;
   localparam int LDPD_WIN_LSB = 5;
   localparam int LDPD_WIN_MSB = 7;
   localparam int LDPD_DRV_LSB = 0;
   localparam int LDPD_DRV_MSB = 2;
   // Reset values
   localparam logic [5:0] LDPD_HTHR_RST = 6'h32;
   localparam logic [7:0] LDPD_PASS_RST = 8'hff;
   localparam logic [4:0] LDPD_ERRC_RST = 5'h00;
   localparam logic [2:0] LDPD_WIN_RST = 3'h0;
   localparam logic [2:0] LDPD_DRV_RST = 3'h0;
   // Interrupt status bits
   localparam int LDPD_IRQ_LOCK_GAIN = 0;
   localparam int LDPD_IRQ_LOCK_LOSS = 1;
   localparam int LDPD_IRQ_CP_HIGH = 2;
   localparam int LDPD_IRQ_N = 3;
   // Edge windows in ps and the phase error resolution in ps
   localparam int LDPD_PHASE_LSB_PS = 100;
   localparam int LDPD_WIN0_PS = 1000;
   localparam int LDPD_WIN1_PS = 1700;
   localparam int LDPD_WIN2_PS = 3000;
   localparam int LDPD_WIN3_PS = 6000;
   localparam int LDPD_WIN4_PS = 10000;
   localparam int LDPD_WIN5_PS = 18000;
   localparam logic [7:0] LDPD_WIN0_CNT = 8'(LDPD_WIN0_PS / LDPD_PHASE_LSB_PS);
   localparam logic [7:0] LDPD_WIN1_CNT = 8'(LDPD_WIN1_PS / LDPD_PHASE_LSB_PS);
   localparam logic [7:0] LDPD_WIN2_CNT = 8'(LDPD_WIN2_PS / LDPD_PHASE_LSB_PS);
   localparam logic [7:0] LDPD_WIN3_CNT = 8'(LDPD_WIN3_PS / LDPD_PHASE_LSB_PS);
   localparam logic [7:0] LDPD_WIN4_CNT = 8'(LDPD_WIN4_PS / LDPD_PHASE_LSB_PS);
   localparam logic [7:0] LDPD_WIN5_CNT = 8'(LDPD_WIN5_PS / LDPD_PHASE_LSB_PS);
   // Window select codes
   localparam logic [2:0] LDPD_WIN_1NS = 3'h0;
   localparam logic [2:0] LDPD_WIN_1P7NS = 3'h1;
   localparam logic [2:0] LDPD_WIN_3NS = 3'h2;
   localparam logic [2:0] LDPD_WIN_6NS = 3'h3;
   localparam logic [2:0] LDPD_WIN_10NS = 3'h4;
   localparam logic [2:0] LDPD_WIN_18NS = 3'h5;
   // Pin drive codes
   typedef enum logic [2:0] {
      LDPD_DRV_TRISTATE = 3'h0,
      LDPD_DRV_OPEN_DRAIN = 3'h1,
      LDPD_DRV_PUSH_PULL = 3'h2,
      LDPD_DRV_RESERVED = 3'h3,
      LDPD_DRV_GROUND = 3'h4,
      LDPD_DRV_INV_OPEN_DRAIN = 3'h5,
      LDPD_DRV_INV_PUSH_PULL = 3'h6,
      LDPD_DRV_INPUT = 3'h7
   } ldpd_drive_t;
   localparam int LDPD_PIN_N = 4;
   localparam logic [7:0] LDPD_CNT_MAX = 8'hff;
endpackage

// ==== hdl/ldpd_top.sv ====
// Lock detector, charge pump flag, pin drive and register file
//
// Contract
// - Read-only flag is 1 while charge pump is above high threshold.
// - Eight-bit pass count, reset 0xff, good edges needed to lock (code locks on good edge pass count + 1).
// - Smaller pass count declares lock after fewer good edges.
// - Five-bit error count, reset 0, errors tolerated before unlock.
// - Edge pair inside window is good, farther apart is an error.
// - Window select, reset 0: 1,1.7,3,6,10,18 ns; 6,7 reserved.
// - Four pins each have 3-bit drive field, reset 0 tristate.
// - Codes: tristate, OD, push-pull, rsvd, ground, inv OD, inv PP, in.
// - Combined lock only with digital lock and charge pump in range.
// - Combined lock low while charge pump below low threshold.
//
// Our own choice: the strobed register port.
`timescale 1ns/10ps
module ldpd_top
   import ldpd_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Phase detector comparison
   input wire logic cmp_valid_i,
   input wire logic [7:0] phase_err_i,
   // Charge pump comparators
   input wire logic cp_above_high_i,
   input wire logic cp_above_low_i,
   output logic [5:0] cp_high_threshold_o,
   output logic cp_voltage_high_flag_o,
   // Lock indicators
   output logic digital_lock_indicator_o,
   output logic combined_lock_indicator_o,
   // Multipurpose pins
   input wire logic [3:0] pin_data_i,
   input wire logic [3:0] pin_in_i,
   output logic [3:0] pin_o,
   output logic [3:0] pin_oe_b_o,
   output logic [3:0] pin_in_o,
   // Interrupt
   output logic irq_o
);

   typedef struct packed {
      logic [5:0] high_thr;
      logic [7:0] pass_cnt;
      logic [4:0] err_lim;
      logic [2:0] win_sel;
      logic [3:0][2:0] drive;
      logic [7:0] rdata;
      logic hi_s1;
      logic hi_s2;
      logic lo_s1;
      logic lo_s2;
      logic [3:0] pin_s1;
      logic [3:0] pin_s2;
      logic [7:0] good_cnt;
      logic [4:0] err_seen;
      logic digital_lock_indicator;
      logic ld;
      logic hi_flag;
      logic [LDPD_IRQ_N-1:0] irq_stat;
      logic [LDPD_IRQ_N-1:0] irq_en;
      logic irq;
      logic [3:0] pin_out;
      logic [3:0] pin_oe_b;
   } ldpd_state_t;

   ldpd_state_t st_reg;
   ldpd_state_t st_next;
   logic [7:0] win_lim;
   logic good_edge;
   logic err_edge;
   logic [LDPD_IRQ_N-1:0] irq_evt;

   // Window limit in phase error units
   always_comb begin
      unique case (st_reg.win_sel)
         LDPD_WIN_1NS: win_lim = LDPD_WIN0_CNT;
         LDPD_WIN_1P7NS: win_lim = LDPD_WIN1_CNT;
         LDPD_WIN_3NS: win_lim = LDPD_WIN2_CNT;
         LDPD_WIN_6NS: win_lim = LDPD_WIN3_CNT;
         LDPD_WIN_10NS: win_lim = LDPD_WIN4_CNT;
         default: win_lim = LDPD_WIN5_CNT;
      endcase
   end

   // Edge classification
   assign good_edge = cmp_valid_i && (phase_err_i <= win_lim);
   assign err_edge = cmp_valid_i && (phase_err_i > win_lim);

   always_comb begin
      st_next = st_reg;
      irq_evt = '0;
      // Synchronisers
      st_next.hi_s1 = cp_above_high_i;
      st_next.hi_s2 = st_reg.hi_s1;
      st_next.lo_s1 = cp_above_low_i;
      st_next.lo_s2 = st_reg.lo_s1;
      st_next.pin_s1 = pin_in_i;
      st_next.pin_s2 = st_reg.pin_s1;
      st_next.hi_flag = st_reg.hi_s2;
      // Register writes
      if (wr_i) begin
         unique case (addr_i)
            LDPD_OFS_CP_HIGH_MONITOR:
               st_next.high_thr = wdata_i[LDPD_HTHR_MSB:LDPD_HTHR_LSB];
            LDPD_OFS_LOCK_PASS_FILTER:
               st_next.pass_cnt = wdata_i;
            LDPD_OFS_LOCK_ERROR_AND_WINDOW: begin
               st_next.err_lim = wdata_i[LDPD_ERRC_MSB:LDPD_ERRC_LSB];
               st_next.win_sel = wdata_i[LDPD_WIN_MSB:LDPD_WIN_LSB];
            end
            LDPD_OFS_TRIGGER1_PIN_CONFIG:
               st_next.drive[0] = wdata_i[LDPD_DRV_MSB:LDPD_DRV_LSB];
            LDPD_OFS_TRIGGER2_PIN_CONFIG:
               st_next.drive[1] = wdata_i[LDPD_DRV_MSB:LDPD_DRV_LSB];
            LDPD_OFS_MODULATION_PIN_CONFIG:
               st_next.drive[2] = wdata_i[LDPD_DRV_MSB:LDPD_DRV_LSB];
            LDPD_OFS_MUX_OUTPUT_PIN_CONFIG:
               st_next.drive[3] = wdata_i[LDPD_DRV_MSB:LDPD_DRV_LSB];
            LDPD_OFS_IRQ_ENABLE:
               st_next.irq_en = wdata_i[LDPD_IRQ_N-1:0];
            default: ;
         endcase
      end
      // Digital lock detector
      if (good_edge) begin
         if (st_reg.good_cnt != LDPD_CNT_MAX) begin
            st_next.good_cnt = st_reg.good_cnt + 8'h01;
         end
         if (!st_reg.digital_lock_indicator && (st_reg.good_cnt >= st_reg.pass_cnt)) begin
            st_next.digital_lock_indicator = 1'b1;
            st_next.err_seen = '0;
         end
      end else if (err_edge) begin
         if (st_reg.err_seen >= st_reg.err_lim) begin
            st_next.digital_lock_indicator = 1'b0;
            st_next.good_cnt = '0;
            st_next.err_seen = '0;
         end else begin
            st_next.err_seen = st_reg.err_seen + 5'h01;
         end
      end
      // Combined lock indicator
      st_next.ld = st_next.digital_lock_indicator && st_reg.lo_s2 && !st_reg.hi_s2;
      // Interrupt events
      irq_evt[LDPD_IRQ_LOCK_GAIN] = st_next.digital_lock_indicator && !st_reg.digital_lock_indicator;
      irq_evt[LDPD_IRQ_LOCK_LOSS] = !st_next.digital_lock_indicator && st_reg.digital_lock_indicator;
      irq_evt[LDPD_IRQ_CP_HIGH] = st_reg.hi_s2 && !st_reg.hi_flag;
      if (wr_i && (addr_i == LDPD_OFS_IRQ_CLEAR)) begin
         st_next.irq_stat = st_reg.irq_stat & ~wdata_i[LDPD_IRQ_N-1:0];
      end
      st_next.irq_stat = st_next.irq_stat | irq_evt;
      st_next.irq = |(st_next.irq_stat & st_next.irq_en);
      // Pin drivers
      for (int i = 0; i < LDPD_PIN_N; i++) begin
         unique case (ldpd_drive_t'(st_next.drive[i]))
            LDPD_DRV_OPEN_DRAIN: begin
               st_next.pin_out[i] = 1'b0;
               st_next.pin_oe_b[i] = pin_data_i[i];
            end
            LDPD_DRV_PUSH_PULL: begin
               st_next.pin_out[i] = pin_data_i[i];
               st_next.pin_oe_b[i] = 1'b0;
            end
            LDPD_DRV_GROUND: begin
               st_next.pin_out[i] = 1'b0;
               st_next.pin_oe_b[i] = 1'b0;
            end
            LDPD_DRV_INV_OPEN_DRAIN: begin
               st_next.pin_out[i] = 1'b0;
               st_next.pin_oe_b[i] = !pin_data_i[i];
            end
            LDPD_DRV_INV_PUSH_PULL: begin
               st_next.pin_out[i] = !pin_data_i[i];
               st_next.pin_oe_b[i] = 1'b0;
            end
            default: begin
               st_next.pin_out[i] = 1'b0;
               st_next.pin_oe_b[i] = 1'b1;
            end
         endcase
      end
      // Read data, one cycle after the strobe
      st_next.rdata = '0;
      if (rd_i) begin
         unique case (addr_i)
            LDPD_OFS_CP_HIGH_MONITOR: begin
               st_next.rdata[LDPD_HTHR_MSB:LDPD_HTHR_LSB] = st_reg.high_thr;
               st_next.rdata[LDPD_HFLAG_BIT] = st_reg.hi_flag;
            end
            LDPD_OFS_LOCK_PASS_FILTER:
               st_next.rdata = st_reg.pass_cnt;
            LDPD_OFS_LOCK_ERROR_AND_WINDOW: begin
               st_next.rdata[LDPD_ERRC_MSB:LDPD_ERRC_LSB] = st_reg.err_lim;
               st_next.rdata[LDPD_WIN_MSB:LDPD_WIN_LSB] = st_reg.win_sel;
            end
            LDPD_OFS_TRIGGER1_PIN_CONFIG:
               st_next.rdata[LDPD_DRV_MSB:LDPD_DRV_LSB] = st_reg.drive[0];
            LDPD_OFS_TRIGGER2_PIN_CONFIG:
               st_next.rdata[LDPD_DRV_MSB:LDPD_DRV_LSB] = st_reg.drive[1];
            LDPD_OFS_MODULATION_PIN_CONFIG:
               st_next.rdata[LDPD_DRV_MSB:LDPD_DRV_LSB] = st_reg.drive[2];
            LDPD_OFS_MUX_OUTPUT_PIN_CONFIG:
               st_next.rdata[LDPD_DRV_MSB:LDPD_DRV_LSB] = st_reg.drive[3];
            LDPD_OFS_IRQ_STATUS:
               st_next.rdata[LDPD_IRQ_N-1:0] = st_reg.irq_stat;
            LDPD_OFS_IRQ_ENABLE:
               st_next.rdata[LDPD_IRQ_N-1:0] = st_reg.irq_en;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_reg <= '0;
         st_reg.high_thr <= LDPD_HTHR_RST;
         st_reg.pass_cnt <= LDPD_PASS_RST;
         st_reg.err_lim <= LDPD_ERRC_RST;
         st_reg.win_sel <= LDPD_WIN_RST;
         st_reg.drive <= {LDPD_PIN_N{LDPD_DRV_RST}};
         st_reg.pin_oe_b <= 4'hf;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs
   assign rdata_o = st_reg.rdata;
   assign cp_high_threshold_o = st_reg.high_thr;
   assign cp_voltage_high_flag_o = st_reg.hi_flag;
   assign digital_lock_indicator_o = st_reg.digital_lock_indicator;
   assign combined_lock_indicator_o = st_reg.ld;
   assign pin_o = st_reg.pin_out;
   assign pin_oe_b_o = st_reg.pin_oe_b;
   assign pin_in_o = st_reg.pin_s2;
   assign irq_o = st_reg.irq;

   // Checks
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_b_i);

   high_flag_follow_a: assert property (
      cp_above_high_i [*4] |-> cp_voltage_high_flag_o)
      else $error("High flag not set after comparator high");
   lock_needs_count_a: assert property (
      $rose(digital_lock_indicator_o) |->
      ($past(st_reg.good_cnt) >= $past(st_reg.pass_cnt)))
      else $error("Lock declared before pass count reached");
   lock_on_good_a: assert property (
      $rose(digital_lock_indicator_o) |-> $past(good_edge))
      else $error("Lock declared without a good edge");
   unlock_on_error_a: assert property (
      $fell(digital_lock_indicator_o) |-> $past(err_edge) &&
      ($past(st_reg.err_seen) >= $past(st_reg.err_lim)))
      else $error("Lock lost without enough error edges");
   zero_err_good_a: assert property (
      cmp_valid_i && (phase_err_i == 8'h00) |-> good_edge && !err_edge)
      else $error("Zero phase error not classed good");
   widest_window_a: assert property (
      (st_reg.win_sel == LDPD_WIN_18NS) |-> (win_lim == LDPD_WIN5_CNT))
      else $error("Wrong limit for widest window");
   ground_drive_a: assert property (
      (st_reg.drive[0] == LDPD_DRV_GROUND) ##1
      (st_reg.drive[0] == LDPD_DRV_GROUND) |-> !pin_o[0] && !pin_oe_b_o[0])
      else $error("Ground code does not drive low");
   ld_needs_dld_a: assert property (
      combined_lock_indicator_o |-> digital_lock_indicator_o)
      else $error("Combined lock without digital lock");
   ld_low_cp_a: assert property (
      !cp_above_low_i [*3] |=> !combined_lock_indicator_o)
      else $error("Combined lock high with charge pump low");
   input_undriven_a: assert property (
      (st_reg.drive[3] == LDPD_DRV_INPUT) ##1
      (st_reg.drive[3] == LDPD_DRV_INPUT) |-> pin_oe_b_o[3])
      else $error("Input pin is driven");

   // Lock detector and charge pump flag checks
   flag_low_follow_a: assert property (
      !cp_above_high_i [*4] |-> !cp_voltage_high_flag_o)
      else $error("High flag set with comparator low");
   pass_wait_a: assert property (
      good_edge && !st_reg.digital_lock_indicator && (st_reg.good_cnt < st_reg.pass_cnt) |=>
      !digital_lock_indicator_o)
      else $error("Lock declared with too few good edges");
   err_tolerated_a: assert property (
      err_edge && st_reg.digital_lock_indicator && (st_reg.err_seen < st_reg.err_lim) |=>
      digital_lock_indicator_o)
      else $error("Lock lost before error count used up");
   reserved_window_a: assert property (
      (st_reg.win_sel > LDPD_WIN_18NS) |-> (win_lim == LDPD_WIN5_CNT))
      else $error("Reserved window code not widest");
   cp_high_unlock_a: assert property (
      cp_above_high_i [*3] |=> !combined_lock_indicator_o)
      else $error("Combined lock high with charge pump high");

   // Pin drive checks
   tristate_undriven_a: assert property (
      (st_reg.drive[0] == LDPD_DRV_TRISTATE) ##1
      (st_reg.drive[0] == LDPD_DRV_TRISTATE) |-> pin_oe_b_o[0])
      else $error("Tristate pin is driven");
   open_drain_a: assert property (
      (st_reg.drive[0] == LDPD_DRV_OPEN_DRAIN) ##1
      (st_reg.drive[0] == LDPD_DRV_OPEN_DRAIN) |->
      !pin_o[0] && (pin_oe_b_o[0] == $past(pin_data_i[0])))
      else $error("Open drain pin drives wrong level");
   push_pull_a: assert property (
      (st_reg.drive[1] == LDPD_DRV_PUSH_PULL) ##1
      (st_reg.drive[1] == LDPD_DRV_PUSH_PULL) |->
      !pin_oe_b_o[1] && (pin_o[1] == $past(pin_data_i[1])))
      else $error("Push pull pin drives wrong level");
   inv_open_drain_a: assert property (
      (st_reg.drive[2] == LDPD_DRV_INV_OPEN_DRAIN) ##1
      (st_reg.drive[2] == LDPD_DRV_INV_OPEN_DRAIN) |->
      !pin_o[2] && (pin_oe_b_o[2] == !$past(pin_data_i[2])))
      else $error("Inverted open drain pin drives wrong level");
   inv_push_pull_a: assert property (
      (st_reg.drive[3] == LDPD_DRV_INV_PUSH_PULL) ##1
      (st_reg.drive[3] == LDPD_DRV_INV_PUSH_PULL) |->
      !pin_oe_b_o[3] && (pin_o[3] == !$past(pin_data_i[3])))
      else $error("Inverted push pull pin drives wrong level");

   // Register and interrupt checks
   irq_level_a: assert property (
      irq_o == (|(st_reg.irq_stat & st_reg.irq_en)))
      else $error("Interrupt does not follow enabled status");
   rdata_idle_a: assert property (
      !$past(rd_i) |-> (rdata_o == 8'h00))
      else $error("Read data not zero outside a read");

   lock_gain_c: cover property ($rose(digital_lock_indicator_o));
   lock_loss_c: cover property ($fell(digital_lock_indicator_o));
   combined_lock_c: cover property ($rose(combined_lock_indicator_o));
   irq_c: cover property ($rose(irq_o));

endmodule

// ==== bench/ldpd_pad_model.sv ====
// Pad model: pull-up on each pin and an external driver for inputs
`timescale 1ns/10ps
module ldpd_pad_model (
   // Device side
   input wire logic [3:0] pin_o,
   input wire logic [3:0] pin_oe_b_o,
   // External driver
   input wire logic [3:0] ext_en_i,
   input wire logic [3:0] ext_val_i,
   // Resolved pad level
   output logic [3:0] pad_o
);
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (!pin_oe_b_o[i])
            pad_o[i] = pin_o[i];
         else if (ext_en_i[i])
            pad_o[i] = ext_val_i[i];
         else
            pad_o[i] = 1'b1;
      end
   end
endmodule

// ==== bench/ldpd_top_tb.sv ====
// Self-checking bench for the lock detect and pin drive block
`timescale 1ns/10ps
module ldpd_top_tb
   import ldpd_pkg::*;
;
   logic clk_sys_i, rst_b_i, wr_i, rd_i, cmp_valid_i, irq_o;
   logic cp_above_high_i, cp_above_low_i, cp_voltage_high_flag_o;
   logic digital_lock_indicator_o, combined_lock_indicator_o;
   logic [7:0] addr_i, wdata_i, phase_err_i, rdata_o;
   logic [5:0] cp_high_threshold_o;
   logic [3:0] pin_data_i, pad, pin_o, pin_oe_b_o, pin_in_o, ext_en;
   int mismatches, cmp_count;
   int lim[8] = '{10, 17, 30, 60, 100, 180, 180, 180};
   logic [3:0] exp_pad[8] = '{4'hf, 4'h5, 4'h5, 4'hf, 4'h0, 4'ha, 4'ha, 4'h3};
   logic [3:0] exp_oe[8] = '{4'hf, 4'h5, 4'h0, 4'hf, 4'h0, 4'ha, 4'h0, 4'hf};
   ldpd_top u_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .cmp_valid_i(cmp_valid_i),
      .phase_err_i(phase_err_i), .cp_above_high_i(cp_above_high_i),
      .cp_above_low_i(cp_above_low_i),
      .cp_high_threshold_o(cp_high_threshold_o),
      .cp_voltage_high_flag_o(cp_voltage_high_flag_o),
      .digital_lock_indicator_o(digital_lock_indicator_o),
      .combined_lock_indicator_o(combined_lock_indicator_o),
      .pin_data_i(pin_data_i), .pin_in_i(pad), .pin_o(pin_o),
      .pin_oe_b_o(pin_oe_b_o), .pin_in_o(pin_in_o), .irq_o(irq_o));
   ldpd_pad_model u_pad (.pin_o(pin_o), .pin_oe_b_o(pin_oe_b_o),
      .ext_en_i(ext_en), .ext_val_i(4'b0011), .pad_o(pad));
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, exp);
   endtask
   task automatic edge_pair(input logic [7:0] p);
      @(posedge clk_sys_i);
      cmp_valid_i <= 1'b1;
      phase_err_i <= p;
      @(posedge clk_sys_i);
      cmp_valid_i <= 1'b0;
      #1;
   endtask
   task automatic t_reset;
      rdchk(8'h21, 8'hff);
      rdchk(8'h22, 8'h00);
      for (int i = 0; i < 4; i++) rdchk(8'h24 + 8'(i), 8'h00);
      rdchk(8'h40, 8'h00);
      chk(pad, 4'hf);
   endtask
   task automatic t_lock;
      wr(8'h2a, 8'h01);
      wr(8'h21, 8'h02);
      edge_pair(8'd10);
      edge_pair(8'd10);
      chk(digital_lock_indicator_o, 1'b0);
      edge_pair(8'd0);
      chk(digital_lock_indicator_o, 1'b1);
      chk(combined_lock_indicator_o, 1'b1);
      cyc(2);
      chk(irq_o, 1'b1);
      rdchk(8'h28, 8'h01);
      wr(8'h29, 8'h01);
      cyc(2);
      chk(irq_o, 1'b0);
      edge_pair(8'd11);
      chk(digital_lock_indicator_o, 1'b0);
      cyc(2);
      chk(irq_o, 1'b0);
      rdchk(8'h28, 8'h02);
      wr(8'h29, 8'h02);
      wr(8'h21, 8'h00);
      edge_pair(8'd5);
      chk(digital_lock_indicator_o, 1'b1);
      @(posedge clk_sys_i);
      cp_above_low_i <= 1'b0;
      cyc(4);
      chk(combined_lock_indicator_o, 1'b0);
      chk(digital_lock_indicator_o, 1'b1);
      @(posedge clk_sys_i);
      cp_above_low_i <= 1'b1;
      cyc(4);
      chk(combined_lock_indicator_o, 1'b1);
   endtask
   task automatic t_errlimit;
      wr(8'h22, 8'h04);
      repeat (4) edge_pair(8'd11);
      chk(digital_lock_indicator_o, 1'b1);
      edge_pair(8'd11);
      chk(digital_lock_indicator_o, 1'b0);
   endtask
   task automatic t_window;
      for (int c = 0; c < 8; c++) begin
         wr(8'h22, {3'(c), 5'h00});
         edge_pair(8'(lim[c]));
         chk(digital_lock_indicator_o, 1'b1);
         edge_pair(8'(lim[c] + 1));
         chk(digital_lock_indicator_o, 1'b0);
      end
   endtask
   task automatic t_high;
      @(posedge clk_sys_i);
      cp_above_high_i <= 1'b1;
      cyc(4);
      chk(cp_voltage_high_flag_o, 1'b1);
      rdchk(8'h1f, 8'h72);
      rdchk(8'h28, 8'h07);
      rdchk(8'h2a, 8'h01);
      chk(irq_o, 1'b1);
      wr(8'h1f, 8'hff);
      rdchk(8'h1f, 8'h7f);
      chk(cp_high_threshold_o, 6'h3f);
      @(posedge clk_sys_i);
      cp_above_high_i <= 1'b0;
      cyc(4);
      chk(cp_voltage_high_flag_o, 1'b0);
      rdchk(8'h1f, 8'h3f);
   endtask
   task automatic t_pins;
      for (int c = 0; c < 8; c++) begin
         @(posedge clk_sys_i);
         ext_en <= (c == 7) ? 4'hf : 4'h0;
         for (int i = 0; i < 4; i++) wr(8'h24 + 8'(i), 8'(c));
         cyc(4);
         chk(pin_oe_b_o, exp_oe[c]);
         chk(pad, exp_pad[c]);
         if (c == 7) chk(pin_in_o, 4'h3);
      end
   endtask
   task automatic complete_run;
      $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #200_000;
      mismatches++;
      complete_run();
   end
   initial begin
      rst_b_i = 1'b0;
      {wr_i, rd_i, cmp_valid_i, cp_above_high_i} = 4'h0;
      cp_above_low_i = 1'b1;
      addr_i = 8'h00;
      wdata_i = 8'h00;
      phase_err_i = 8'h00;
      pin_data_i = 4'b0101;
      ext_en = 4'h0;
      cyc(2);
      chk(pin_oe_b_o, 4'hf);
      @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      t_reset();
      t_lock();
      t_errlimit();
      t_window();
      t_high();
      t_pins();
      complete_run();
   end
endmodule
